// ===== rtl/dac_chain_pkg.sv
// Constants, register map and types shared by the playback output chain
`default_nettype none
package dac_chain_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_FILTER_ONE  = 4'h0;
  localparam logic [3:0] ADDR_GAIN_L      = 4'h1;
  localparam logic [3:0] ADDR_GAIN_R      = 4'h2;
  localparam logic [3:0] ADDR_EQ_CTRL     = 4'h3;
  localparam logic [3:0] ADDR_BAND_FIRST  = 4'h4;
  localparam logic [3:0] ADDR_BAND_LAST   = 4'h8;
  localparam logic [3:0] ADDR_FILTER_FIVE = 4'h9;
  localparam logic [3:0] ADDR_STAT_L      = 4'hA;
  localparam logic [3:0] ADDR_STAT_R      = 4'hB;
  localparam logic [3:0] ADDR_RAMP_STAT   = 4'hC;
  // Field positions in playback_filter_config_one and _five
  localparam int HPF_EN_BIT    = 0;
  localparam int AUDIO_CRN_LSB = 1;
  localparam int VOICE_EN_BIT  = 3;
  localparam int VOICE_CRN_LSB = 4;
  localparam int SOFTMUTE_BIT  = 0;
  localparam int RAMP_PER_LSB  = 1;
  // Values after reset
  localparam logic [6:0] FILTER_ONE_RST = 7'h01;
  localparam logic [6:0] GAIN_RST       = 7'h68;
  localparam logic [3:0] BAND_RST       = 4'h7;
  localparam logic [4:0] FILTER_FIVE_RST = 5'h00;
  // Gain scale: code 0 mutes, code 120 is the top step
  localparam logic [6:0] GAIN_MAX   = 7'h78;
  localparam logic [8:0] GAIN_Q_MAX = 9'h1E0;
  localparam logic [8:0] Q_FLOOR    = 9'h004;
  localparam logic [9:0] EQ_CUT     = 10'h040;
  // Linear factor per 0.75 dB step over one 6 dB octave, Q15
  localparam logic [15:0] MANT [0:8] = '{16'h8000, 16'h7569, 16'h6BB3, 16'h62CA,
                                         16'h5A9E, 16'h531F, 16'h4C3F, 16'h45F0, 16'h4000};
  // Tracker coefficients, Q16 of the sample rate
  localparam logic [15:0] AUDIO_COEF [0:3] = '{16'h0011, 16'h0022, 16'h0045, 16'h0089};
  localparam logic [15:0] VOICE_COEF [0:7] = '{16'h0081, 16'h0507, 16'h0A0E, 16'h141B,
                                               16'h1E29, 16'h2836, 16'h3C51, 16'h506C};
  // Band splitter shifts; corners track the sample rate
  localparam int EQ_SHIFT [0:3] = '{6, 4, 2, 1};
  typedef enum logic [1:0] {RUN, DOWN, MUTED, UP} mute_state_t;
endpackage
`default_nettype wire

// ===== rtl/sample_if.sv
// Stream of one channel's samples between stages
`timescale 1ns/1ps
`default_nettype none
interface sample_if #(
  parameter int W = 24
);
  logic                valid;
  logic signed [W-1:0] data;
  modport src (output valid, output data);
  modport snk (input valid, input data);
endinterface
`default_nettype wire

// ===== rtl/hpf_channel.sv
// DC-removal high-pass filter for one channel
`timescale 1ns/1ps
`default_nettype none
module hpf_channel #(
  parameter int SW = 24
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Configuration
  input  wire logic        enable,
  input  wire logic [15:0] coef,
  // Streams
  sample_if.snk            sin,
  sample_if.src            sout
);
  typedef struct packed {
    logic           valid;
    logic [SW-1:0]  data;
    logic [SW+15:0] dc;
  } hpf_state_t;

  hpf_state_t          s_reg;
  hpf_state_t          s_next;
  logic signed [SW+16:0] diff;
  logic signed [SW+33:0] prod;
  logic signed [SW:0]    y;

  always_comb
  begin
    s_next = s_reg;
    s_next.valid = sin.valid;
    diff = {sin.data[SW-1], sin.data, 16'h0000} - {s_reg.dc[SW+15], $signed(s_reg.dc)};
    prod = diff * $signed({1'b0, coef});
    y = {sin.data[SW-1], sin.data} - {s_reg.dc[SW+15], s_reg.dc[SW+15:16]};
    if (sin.valid)
    begin
      if (enable)
      begin
        // Tracker keeps 16 fraction bits so the lowest corners do not stall
        s_next.dc = s_reg.dc + prod[SW+31:16];
        if (y[SW] != y[SW-1])
          s_next.data = y[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
        else
          s_next.data = y[SW-1:0];
      end
      else
      begin
        // Bypass clears the tracker so a re-enable starts clean
        s_next.dc = '0;
        s_next.data = sin.data;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign sout.valid = s_reg.valid;
  assign sout.data  = s_reg.data;

  property p_hpf_bypass;
    @(posedge clk) disable iff (!rstn)
    (!enable && sin.valid) |=> (sout.valid && sout.data == $past(sin.data));
  endproperty
  a_hpf_bypass: assert property (p_hpf_bypass) else $error("bypass altered sample");
endmodule
`default_nettype wire

// ===== rtl/dac_output_processing_chain.sv
// Playback output chain: high-pass, 5-band equalizer, digital gain and soft mute
//
// Functional notes
// - Each channel has its own gain, 0.75 dB steps, -78 dB mutes to +12 dB.
// - Per-channel status shows the gain in effect, apart from the setting.
// - High-pass DC removal on both channels, on after reset, bypass when cleared.
// - Audio corner is a 2-bit code, doubling per step, scaling with rate.
// - Voice filtering only when voice enable and high-pass enable are both set.
// - Voice corner is a 3-bit code scaling with rate, good up to 16 kHz.
// - Five band gains, -10.5 dB to +12 dB in 1.5 dB steps.
// - One enable switches the equalizer on for both channels.
// - Equalizer on cuts path gain by 12 dB; channel gain may restore it.
// - Band corners follow the output sample rate.
// - Soft mute ramps down 0.1875 dB steps to -77.25 dB, then mutes.
// - Release starts at -77.25 dB and ramps back to the prior gain.
// - One soft-mute control acts on both channels together.
// - Ramp step rate follows sample rate and is configurable.
// - During a ramp the applied gain may differ from the status value.
`timescale 1ns/1ps
`default_nettype none
module dac_output_processing_chain #(
  parameter int SW = 24
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Register port
  input  wire logic [3:0]    addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          we,
  input  wire logic          re,
  output logic [7:0]         rdata,
  // Samples from the router
  input  wire logic          in_valid,
  input  wire logic [SW-1:0] in_left,
  input  wire logic [SW-1:0] in_right,
  // Samples to the DAC
  output logic               out_valid,
  output logic [SW-1:0]      out_left,
  output logic [SW-1:0]      out_right
);
  localparam logic signed [47:0] SMAX = 48'((64'sd1 <<< (SW - 1)) - 64'sd1);
  localparam logic signed [47:0] SMIN = -SMAX - 48'sh1;

  typedef struct packed {
    logic [6:0]              filt_one;
    logic [6:0]              gain_l;
    logic [6:0]              gain_r;
    logic                    eq_en;
    logic [4:0][3:0]         band;
    logic [4:0]              filt_five;
    logic [7:0]              rdata;
    logic [1:0][3:0][SW+9:0] lp;
    dac_chain_pkg::mute_state_t mst;
    logic [8:0]              q_l;
    logic [8:0]              q_r;
    logic [3:0]              cnt;
    logic                    ov;
    logic [SW-1:0]           ol;
    logic [SW-1:0]           orr;
  } chain_state_t;

  chain_state_t          s_reg;
  chain_state_t          s_next;
  logic                  voice_mode;
  logic [15:0]           coef;
  logic                  hv;
  logic                  tick;
  logic                  sm;
  logic [8:0]            tl;
  logic [8:0]            tr;
  logic [9:0]            att_l;
  logic [9:0]            att_r;
  logic signed [SW-1:0]  xs [2];
  logic signed [SW+9:0]  ext [2];
  logic signed [SW+9:0]  nl [2][4];
  logic signed [SW+9:0]  bd [2][5];
  logic signed [47:0]    acc [2];
  logic signed [SW-1:0]  eqo [2];
  logic [SW-1:0]         y [2];

  sample_if #(.W(SW)) hin_l ();
  sample_if #(.W(SW)) hin_r ();
  sample_if #(.W(SW)) hout_l ();
  sample_if #(.W(SW)) hout_r ();

  // Scale by a level given in 0.1875 dB units below +12 dB
  function automatic logic signed [47:0] scale(input logic signed [SW+1:0] s,
                                               input logic [9:0] att);
    logic [3:0]         idx;
    logic [15:0]        m0;
    logic [15:0]        d;
    logic [17:0]        dm;
    logic [15:0]        m;
    logic signed [47:0] p;
    idx = {1'b0, att[4:2]};
    m0 = dac_chain_pkg::MANT[idx];
    d = m0 - dac_chain_pkg::MANT[idx + 4'h1];
    dm = 18'(d) * 18'(att[1:0]);
    m = m0 - dm[17:2];
    p = s * $signed({1'b0, m});
    return p >>> (6'd13 + {1'b0, att[9:5]});
  endfunction

  function automatic logic [SW-1:0] sat(input logic signed [47:0] v);
    if (v > SMAX)
      return SMAX[SW-1:0];
    else if (v < SMIN)
      return SMIN[SW-1:0];
    else
      return v[SW-1:0];
  endfunction

  function automatic logic [6:0] clamp_gain(input logic [6:0] g);
    return (g > dac_chain_pkg::GAIN_MAX) ? dac_chain_pkg::GAIN_MAX : g;
  endfunction

  assign voice_mode = s_reg.filt_one[dac_chain_pkg::VOICE_EN_BIT]
                    & s_reg.filt_one[dac_chain_pkg::HPF_EN_BIT];
  // Fixed Q16 coefficients keep each corner a fixed fraction of the rate
  assign coef = voice_mode
              ? dac_chain_pkg::VOICE_COEF[s_reg.filt_one[dac_chain_pkg::VOICE_CRN_LSB +: 3]]
              : dac_chain_pkg::AUDIO_COEF[s_reg.filt_one[dac_chain_pkg::AUDIO_CRN_LSB +: 2]];

  assign hin_l.valid = in_valid;
  assign hin_l.data  = in_left;
  assign hin_r.valid = in_valid;
  assign hin_r.data  = in_right;

  hpf_channel #(.SW(SW)) u_hpf_l (
    .clk    (clk),
    .rstn   (rstn),
    .enable (s_reg.filt_one[dac_chain_pkg::HPF_EN_BIT]),
    .coef   (coef),
    .sin    (hin_l),
    .sout   (hout_l)
  );

  hpf_channel #(.SW(SW)) u_hpf_r (
    .clk    (clk),
    .rstn   (rstn),
    .enable (s_reg.filt_one[dac_chain_pkg::HPF_EN_BIT]),
    .coef   (coef),
    .sin    (hin_r),
    .sout   (hout_r)
  );

  assign hv = hout_l.valid;
  assign sm = s_reg.filt_five[dac_chain_pkg::SOFTMUTE_BIT];
  assign tl = {s_reg.gain_l, 2'b00};
  assign tr = {s_reg.gain_r, 2'b00};
  assign tick = hv && (s_reg.cnt == s_reg.filt_five[dac_chain_pkg::RAMP_PER_LSB +: 4]);
  assign att_l = {1'b0, dac_chain_pkg::GAIN_Q_MAX} - {1'b0, s_reg.q_l}
               + (s_reg.eq_en ? dac_chain_pkg::EQ_CUT : 10'h000);
  assign att_r = {1'b0, dac_chain_pkg::GAIN_Q_MAX} - {1'b0, s_reg.q_r}
               + (s_reg.eq_en ? dac_chain_pkg::EQ_CUT : 10'h000);

  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = 8'h00;
    s_next.ov = hv;
    xs[0] = hout_l.data;
    xs[1] = hout_r.data;
    if (we)
    begin
      case (addr)
        dac_chain_pkg::ADDR_FILTER_ONE:  s_next.filt_one = wdata[6:0];
        dac_chain_pkg::ADDR_GAIN_L:      s_next.gain_l = clamp_gain(wdata[6:0]);
        dac_chain_pkg::ADDR_GAIN_R:      s_next.gain_r = clamp_gain(wdata[6:0]);
        dac_chain_pkg::ADDR_EQ_CTRL:     s_next.eq_en = wdata[0];
        dac_chain_pkg::ADDR_FILTER_FIVE: s_next.filt_five = wdata[4:0];
        default:
        begin
          if (addr >= dac_chain_pkg::ADDR_BAND_FIRST && addr <= dac_chain_pkg::ADDR_BAND_LAST)
            s_next.band[3'(addr - dac_chain_pkg::ADDR_BAND_FIRST)] = wdata[3:0];
        end
      endcase
    end
    if (re)
    begin
      case (addr)
        dac_chain_pkg::ADDR_FILTER_ONE:  s_next.rdata = {1'b0, s_reg.filt_one};
        dac_chain_pkg::ADDR_GAIN_L:      s_next.rdata = {1'b0, s_reg.gain_l};
        dac_chain_pkg::ADDR_GAIN_R:      s_next.rdata = {1'b0, s_reg.gain_r};
        dac_chain_pkg::ADDR_EQ_CTRL:     s_next.rdata = {7'h00, s_reg.eq_en};
        dac_chain_pkg::ADDR_FILTER_FIVE: s_next.rdata = {3'h0, s_reg.filt_five};
        // Status rounds the ramp level down to whole gain steps
        dac_chain_pkg::ADDR_STAT_L:      s_next.rdata = {1'b0, s_reg.q_l[8:2]};
        dac_chain_pkg::ADDR_STAT_R:      s_next.rdata = {1'b0, s_reg.q_r[8:2]};
        dac_chain_pkg::ADDR_RAMP_STAT:
          s_next.rdata = {6'h00, s_reg.mst == dac_chain_pkg::DOWN || s_reg.mst == dac_chain_pkg::UP,
                          s_reg.mst == dac_chain_pkg::MUTED};
        default:
        begin
          if (addr >= dac_chain_pkg::ADDR_BAND_FIRST && addr <= dac_chain_pkg::ADDR_BAND_LAST)
            s_next.rdata = {4'h0, s_reg.band[3'(addr - dac_chain_pkg::ADDR_BAND_FIRST)]};
        end
      endcase
    end

    // Sample counter paces the ramp; held at zero only in RUN, it keeps counting while muted
    if (s_reg.mst == dac_chain_pkg::RUN || tick)
      s_next.cnt = 4'h0;
    else if (hv)
      s_next.cnt = s_reg.cnt + 4'h1;
    // One shared ramp machine keeps both channels in step
    case (s_reg.mst)
      dac_chain_pkg::RUN:
      begin
        s_next.q_l = tl;
        s_next.q_r = tr;
        if (sm)
          s_next.mst = dac_chain_pkg::DOWN;
      end
      dac_chain_pkg::DOWN:
      begin
        if (!sm)
          s_next.mst = dac_chain_pkg::UP;
        else if (tick)
        begin
          // The floor level is held at least one step period before full mute
          if (s_reg.q_l <= dac_chain_pkg::Q_FLOOR && s_reg.q_r <= dac_chain_pkg::Q_FLOOR)
          begin
            s_next.q_l = 9'h000;
            s_next.q_r = 9'h000;
            s_next.mst = dac_chain_pkg::MUTED;
          end
          else
          begin
            if (s_reg.q_l > dac_chain_pkg::Q_FLOOR)
              s_next.q_l = s_reg.q_l - 9'h001;
            if (s_reg.q_r > dac_chain_pkg::Q_FLOOR)
              s_next.q_r = s_reg.q_r - 9'h001;
          end
        end
      end
      dac_chain_pkg::MUTED:
      begin
        if (!sm)
        begin
          s_next.mst = dac_chain_pkg::UP;
          s_next.q_l = (tl == 9'h000) ? 9'h000 : dac_chain_pkg::Q_FLOOR;
          s_next.q_r = (tr == 9'h000) ? 9'h000 : dac_chain_pkg::Q_FLOOR;
        end
      end
      dac_chain_pkg::UP:
      begin
        if (sm)
          s_next.mst = dac_chain_pkg::DOWN;
        else
        begin
          // A target lowered mid-ramp is met on the next tick rather than overshot
          if (tick)
          begin
            s_next.q_l = (s_reg.q_l < tl) ? s_reg.q_l + 9'h001 : tl;
            s_next.q_r = (s_reg.q_r < tr) ? s_reg.q_r + 9'h001 : tr;
          end
          if (s_next.q_l == tl && s_next.q_r == tr)
            s_next.mst = dac_chain_pkg::RUN;
        end
      end
      default: s_next.mst = dac_chain_pkg::RUN;
    endcase

    // Equalizer then gain on the high-passed sample
    for (int c = 0; c < 2; c++)
    begin
      ext[c] = {{2{xs[c][SW-1]}}, xs[c], 8'h00};
      for (int i = 0; i < 4; i++)
        nl[c][i] = $signed(s_reg.lp[c][i])
                 + ((ext[c] - $signed(s_reg.lp[c][i])) >>> dac_chain_pkg::EQ_SHIFT[i]);
      bd[c][0] = nl[c][0];
      for (int i = 1; i < 4; i++)
        bd[c][i] = nl[c][i] - nl[c][i-1];
      bd[c][4] = ext[c] - nl[c][3];
      acc[c] = '0;
      for (int i = 0; i < 5; i++)
        acc[c] = acc[c] + scale(bd[c][i][SW+9:8], {3'h0, 4'hF - s_reg.band[i], 3'h0});
      eqo[c] = s_reg.eq_en ? sat(acc[c]) : xs[c];
    end
    // Code 0 and the muted state give exact silence
    y[0] = (s_reg.q_l == 9'h000) ? '0 : sat(scale({{2{eqo[0][SW-1]}}, eqo[0]}, att_l));
    y[1] = (s_reg.q_r == 9'h000) ? '0 : sat(scale({{2{eqo[1][SW-1]}}, eqo[1]}, att_r));
    if (hv)
    begin
      for (int c = 0; c < 2; c++)
        for (int i = 0; i < 4; i++)
          s_next.lp[c][i] = nl[c][i];
      s_next.ol = y[0];
      s_next.orr = y[1];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.filt_one <= dac_chain_pkg::FILTER_ONE_RST;
      s_reg.gain_l <= dac_chain_pkg::GAIN_RST;
      s_reg.gain_r <= dac_chain_pkg::GAIN_RST;
      s_reg.band <= {5{dac_chain_pkg::BAND_RST}};
      s_reg.filt_five <= dac_chain_pkg::FILTER_FIVE_RST;
      s_reg.q_l <= {dac_chain_pkg::GAIN_RST, 2'b00};
      s_reg.q_r <= {dac_chain_pkg::GAIN_RST, 2'b00};
      s_reg.mst <= dac_chain_pkg::RUN;
    end
    else
      s_reg <= s_next;
  end

  assign rdata     = s_reg.rdata;
  assign out_valid = s_reg.ov;
  assign out_left  = s_reg.ol;
  assign out_right = s_reg.orr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // The ramp level follows the code one cycle late, so the code must have stood a cycle
  property p_mute_code;
    (s_reg.mst == dac_chain_pkg::RUN && s_reg.gain_r == 7'h00
      && $past(s_reg.gain_r) == 7'h00 && hv) |=> (out_right == '0);
  endproperty
  a_mute_code: assert property (p_mute_code) else $error("gain code 0 not silent");
  property p_status_run;
    (s_reg.mst == dac_chain_pkg::RUN && re && addr == dac_chain_pkg::ADDR_STAT_L
      && $stable(s_reg.gain_l)) |=> (rdata == {1'b0, $past(s_reg.gain_l)});
  endproperty
  a_status_run: assert property (p_status_run) else $error("status differs at rest");
  property p_voice_gate;
    (s_reg.filt_one[dac_chain_pkg::VOICE_EN_BIT] && !s_reg.filt_one[dac_chain_pkg::HPF_EN_BIT])
      |-> (coef == dac_chain_pkg::AUDIO_COEF[s_reg.filt_one[dac_chain_pkg::AUDIO_CRN_LSB +: 2]]);
  endproperty
  a_voice_gate: assert property (p_voice_gate) else $error("voice mode without hpf");
  property p_eq_cut;
    (s_reg.eq_en && s_reg.q_l == dac_chain_pkg::GAIN_Q_MAX) |-> (att_l == 10'h040);
  endproperty
  a_eq_cut: assert property (p_eq_cut) else $error("eq cut not 12 dB");
  property p_down_step;
    (s_reg.mst == dac_chain_pkg::DOWN && sm && s_reg.q_l > 9'h004)
      |=> (s_reg.q_l == $past(s_reg.q_l) || s_reg.q_l == $past(s_reg.q_l) - 9'h001);
  endproperty
  a_down_step: assert property (p_down_step) else $error("ramp down step wrong");
  property p_muted_zero;
    (s_reg.mst == dac_chain_pkg::MUTED) |-> (s_reg.q_l == 9'h000 && s_reg.q_r == 9'h000);
  endproperty
  a_muted_zero: assert property (p_muted_zero) else $error("muted with gain left");
  property p_release;
    (s_reg.mst == dac_chain_pkg::MUTED && !sm && s_reg.gain_l != 7'h00)
      |=> (s_reg.mst == dac_chain_pkg::UP && s_reg.q_l == 9'h004);
  endproperty
  a_release: assert property (p_release) else $error("release not at floor");
  property p_pace;
    ((s_reg.mst == dac_chain_pkg::DOWN || s_reg.mst == dac_chain_pkg::UP) && !tick)
      |=> (s_reg.q_l == $past(s_reg.q_l) && s_reg.q_r == $past(s_reg.q_r));
  endproperty
  a_pace: assert property (p_pace) else $error("ramp moved off tick");
  property p_order;
    in_valid |-> ##2 out_valid;
  endproperty
  a_order: assert property (p_order) else $error("output not two cycles on");

  c_muted: cover property (s_reg.mst == dac_chain_pkg::MUTED);
  c_back:  cover property (s_reg.mst == dac_chain_pkg::UP ##1 s_reg.mst == dac_chain_pkg::RUN);
  c_eq:    cover property (s_reg.eq_en && out_valid);
  c_voice: cover property (voice_mode && hv);
endmodule
`default_nettype wire

// ===== sim/router_dac_model.sv
// Behavioural router feeding stereo samples and DAC capturing the chain output
`timescale 1ns/1ps
`default_nettype none
module router_dac_model #(
  parameter int SW = 24
) (
  // Clock
  input  wire logic          clk,
  // Towards the chain
  output logic               in_valid,
  output logic [SW-1:0]      in_left,
  output logic [SW-1:0]      in_right,
  // From the chain
  input  wire logic          out_valid,
  input  wire logic [SW-1:0] out_left,
  input  wire logic [SW-1:0] out_right
);
  int            cyc = 0;
  int            t_in = 0;
  int            lat = 0;
  logic [SW-1:0] got_l = '0;
  logic [SW-1:0] got_r = '0;

  initial
  begin
    in_valid = 1'b0;
    in_left  = '0;
    in_right = '0;
  end

  // One stereo pair per sample; released data lines flip so stale values never pass
  // Sample rate stays at the audio rates the equalizer supports
  task automatic send(input logic [SW-1:0] l, input logic [SW-1:0] r);
    @(posedge clk);
    in_valid <= 1'b1;
    in_left  <= l;
    in_right <= r;
    @(posedge clk);
    in_valid <= 1'b0;
    in_left  <= ~l;
    in_right <= ~r;
    repeat (3) @(posedge clk);
    #1;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (in_valid)
      t_in <= cyc;
    if (out_valid)
    begin
      lat   <= cyc - t_in;
      got_l <= out_left;
      got_r <= out_right;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the playback output chain
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SW = 24;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [3:0]        addr = 4'h0;
  logic [7:0]        wdata = 8'h00;
  logic              we = 1'b0;
  logic              re = 1'b0;
  logic [7:0]        rdata;
  logic              in_valid;
  logic [SW-1:0]     in_left;
  logic [SW-1:0]     in_right;
  logic              out_valid;
  logic [SW-1:0]     out_left;
  logic [SW-1:0]     out_right;
  int                error_cnt = 0;
  int                samples_checked = 0;
  logic [7:0]        v;
  logic signed [31:0] r [0:3];
  int                n;

  always #25 clk = ~clk;

  dac_output_processing_chain #(.SW(SW)) uut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
    .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
    .out_valid(out_valid), .out_left(out_left), .out_right(out_right));

  router_dac_model #(.SW(SW)) pm (
    .clk(clk), .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
    .out_valid(out_valid), .out_left(out_left), .out_right(out_right));

  function automatic logic signed [31:0] sx(input logic [SW-1:0] x);
    logic signed [SW-1:0] s;
    s = x;
    return s;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(nm, {24'h0, d}, {24'h0, e});
  endtask

  task automatic reset_dut;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
  endtask

  task automatic run(input int k);
    repeat (k) pm.send(24'h100000, 24'h100000);
  endtask

  // Counts samples until the muted flag shows; bounded so a stuck ramp fails the range check
  task automatic mute_count(input logic [3:0] p, output int c);
    logic [7:0] st;
    wr(dac_chain_pkg::ADDR_FILTER_FIVE, {3'h0, p, 1'b1});
    c = 0;
    st = 8'h00;
    while (st[0] !== 1'b1 && c < 2000)
    begin
      pm.send(24'h100000, 24'h100000);
      rd(dac_chain_pkg::ADDR_RAMP_STAT, st);
      c++;
    end
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    reset_dut();
    rchk("filter_one", dac_chain_pkg::ADDR_FILTER_ONE, 8'h01);
    rchk("gain_l", dac_chain_pkg::ADDR_GAIN_L, 8'h68);
    rchk("gain_r", dac_chain_pkg::ADDR_GAIN_R, 8'h68);
    rchk("eq_ctrl", dac_chain_pkg::ADDR_EQ_CTRL, 8'h00);
    for (int b = 4; b <= 8; b++)
      rchk("band", 4'(b), 8'h07);
    rchk("filter_five", dac_chain_pkg::ADDR_FILTER_FIVE, 8'h00);
    rchk("ramp_stat", dac_chain_pkg::ADDR_RAMP_STAT, 8'h00);
    wr(dac_chain_pkg::ADDR_GAIN_L, 8'h7F);
    wr(dac_chain_pkg::ADDR_STAT_L, 8'h10);
    wr(4'hD, 8'h55);
    wr(dac_chain_pkg::ADDR_BAND_LAST, 8'hFF);
    rchk("gain_clamp", dac_chain_pkg::ADDR_GAIN_L, 8'h78);
    rchk("stat_l", dac_chain_pkg::ADDR_STAT_L, 8'h78);
    rchk("stat_r", dac_chain_pkg::ADDR_STAT_R, 8'h68);
    rchk("unmapped", 4'hD, 8'h00);
    rchk("band5", dac_chain_pkg::ADDR_BAND_LAST, 8'h0F);
    $display("Test registers done");

    wr(dac_chain_pkg::ADDR_FILTER_ONE, 8'h00);
    wr(dac_chain_pkg::ADDR_BAND_LAST, 8'h07);
    wr(dac_chain_pkg::ADDR_GAIN_R, 8'h60);
    pm.send(24'h100000, 24'hF00000);
    check("latency", pm.lat, 32'h2);
    check("plus12", sx(pm.got_l), 32'h00400000);
    check("minus6", sx(pm.got_r), 32'hFFF80000);
    wr(dac_chain_pkg::ADDR_GAIN_R, 8'h00);
    pm.send(24'h100000, 24'hF00000);
    check("mute_code", sx(pm.got_r), 32'h0);
    $display("Test gain done");

    wr(dac_chain_pkg::ADDR_GAIN_L, 8'h68);
    wr(dac_chain_pkg::ADDR_GAIN_R, 8'h68);
    wr(dac_chain_pkg::ADDR_EQ_CTRL, 8'h01);
    pm.send(24'h100000, 24'h100000);
    check("eq_cut_l", (sx(pm.got_l) - 32'sh40000) inside {[-8 : 8]}, 32'h1);
    check("eq_cut_r", (sx(pm.got_r) - 32'sh40000) inside {[-8 : 8]}, 32'h1);
    wr(dac_chain_pkg::ADDR_GAIN_L, 8'h78);
    wr(dac_chain_pkg::ADDR_BAND_FIRST, 8'h0F);
    run(700);
    check("eq_band1", (sx(pm.got_l) - 32'sh400000) inside {[-32'sh40000 : 32'sh40000]}, 32'h1);
    check("eq_band_dc", (sx(pm.got_r) - 32'sh100000) inside {[-32'sh10000 : 32'sh10000]}, 32'h1);
    wr(dac_chain_pkg::ADDR_EQ_CTRL, 8'h00);
    wr(dac_chain_pkg::ADDR_GAIN_L, 8'h68);
    pm.send(24'h100000, 24'h100000);
    check("eq_off", sx(pm.got_l), 32'h00100000);
    $display("Test equalizer done");

    for (int c = 0; c < 4; c++)
    begin
      reset_dut();
      wr(dac_chain_pkg::ADDR_FILTER_ONE, {5'h0, 2'(c), 1'b1});
      run(200);
      r[c] = sx(pm.got_l);
    end
    check("hpf_decay", r[0] < 32'sh100000, 32'h1);
    for (int c = 0; c < 3; c++)
      check("hpf_corner", r[c + 1] < r[c], 32'h1);
    reset_dut();
    wr(dac_chain_pkg::ADDR_FILTER_ONE, 8'h79);
    run(60);
    check("voice_fast", sx(pm.got_l) inside {[-255 : 255]}, 32'h1);
    reset_dut();
    wr(dac_chain_pkg::ADDR_FILTER_ONE, 8'h09);
    run(60);
    check("voice_slow", sx(pm.got_l) > 32'shC0000, 32'h1);
    wr(dac_chain_pkg::ADDR_FILTER_ONE, 8'h78);
    pm.send(24'h100000, 24'h100000);
    check("voice_needs_hpf", sx(pm.got_l), 32'h00100000);
    $display("Test high-pass done");

    wr(dac_chain_pkg::ADDR_GAIN_R, 8'h40);
    mute_count(4'h0, n);
    check("ramp_p0", n inside {[410 : 416]}, 32'h1);
    pm.send(24'h100000, 24'h100000);
    check("muted_l", sx(pm.got_l), 32'h0);
    check("muted_r", sx(pm.got_r), 32'h0);
    wr(dac_chain_pkg::ADDR_FILTER_FIVE, 8'h00);
    pm.send(24'h100000, 24'h100000);
    check("release_low", sx(pm.got_l) inside {[1 : 511]}, 32'h1);
    rchk("stat_ramp", dac_chain_pkg::ADDR_STAT_L, 8'h01);
    n = 0;
    v = 8'h02;
    while (v !== 8'h00 && n < 2000)
    begin
      pm.send(24'h100000, 24'h100000);
      rd(dac_chain_pkg::ADDR_RAMP_STAT, v);
      n++;
    end
    check("release_done", v, 8'h00);
    pm.send(24'h100000, 24'h100000);
    check("restored_l", sx(pm.got_l), 32'h00100000);
    check("restored_r", sx(pm.got_r) inside {[32'sh7C00 : 32'sh8400]}, 32'h1);
    rchk("stat_after", dac_chain_pkg::ADDR_STAT_L, 8'h68);
    reset_dut();
    wr(dac_chain_pkg::ADDR_FILTER_ONE, 8'h00);
    mute_count(4'h1, n);
    check("ramp_p1", n inside {[820 : 832]}, 32'h1);
    $display("Test soft mute done");
    wrap_up();
  end
endmodule
`default_nettype wire
